// ===== logic/lfs_map.svh
// constants for the led fault supervisor: timing counts, channel count and counter width
// ------------------------------------------------------------
// Notes on behaviour
// [R1] overvoltage comparator active stops boost switching while it lasts
// [R2] boost resumes after overvoltage clears; stops again on each new trip
// [R3] open string at overvoltage is removed; regulation then continues
// [R4] switch-node overvoltage latches fault until enable shutdown or lockout
// [R5] string detection completes before boost enable; diode check only then
// [R6] primary current limit ends the on-time; next cycle runs normally
// [R7] secondary current limit shuts boost, sinks and disconnect at once
// [R8] input sense trip shuts down within 3 us regardless of enable, latched
// [R9] input overcurrent asserts fault flag and turns off disconnect gate
// [R10] enable only when supply and sense both above rising threshold
// [R11] supply below falling threshold over 50 us disables; dips ignored
// [R12] supply below 4.35 V shuts the device down
// [R13] enable low past shutdown-low time: low power, all latches cleared
// [R14] shutdown-low time counted on the internal clock, 16.3 ms at 2 MHz
// [R15] in shutdown all sources off until enable returns high
// [R16] selected detectors masked during startup
// [R17] host wanting fast shutdown uses the frequency-set pin path
// [R18] latched fault clears after enable low for 32750 clock cycles
// [R19] enable high runs boost and sinks; enable low turns both off
// [R20] shorted channels rechecked on each rising enable edge
// [R21] deglitch and shutdown intervals counted, restarting on condition loss
// ------------------------------------------------------------
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

`define LFS_CLK_MHZ 250
`define LFS_UV_DEGLITCH_US 50
`define LFS_UV_DEGLITCH_CYC (`LFS_UV_DEGLITCH_US * `LFS_CLK_MHZ)
`define LFS_SHUTDOWN_CYC 32750
`define LFS_START_MASK_CYC 1024
`define LFS_CHANNELS 2
`define LFS_CNT_W 16

`endif

// ===== logic/lfs_pkg.sv
// types for the led fault supervisor
package lfs_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_DETECT = 4'b0010,
        ST_RUN = 4'b0100,
        ST_LATCH = 4'b1000
    } lfs_state_t;

    // comparator inputs grouped after synchronising
    typedef struct packed {
        logic overVolt;
        logic nodeOverVolt;
        logic primLimit;
        logic secLimit;
        logic inputTrip;
        logic supplyAboveRise;
        logic senseAboveRise;
        logic supplyBelowFall;
        logic supplyBelowAbs;
    } lfs_sense_t;
endpackage : lfs_pkg

// ===== logic/lfs_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module lfs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] firstStage_reg;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            firstStage_reg <= '0;
            syncOut <= '0;
        end else begin
            firstStage_reg <= asyncIn;
            syncOut <= firstStage_reg;
        end
    end
endmodule : lfs_sync

// ===== logic/lfs_timer.sv
// interval counter: done once the condition held for LIMIT cycles
`timescale 1ns/10ps
module lfs_timer #(
    parameter int LIMIT = 16,
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // condition and result
    input wire logic hold,
    output logic done
);
    logic [CNT_W-1:0] count_reg;
    wire atLimit = (count_reg >= CNT_W'(LIMIT - 1));

    // refuse limits that the counter width cannot reach
    if (LIMIT < 1 || LIMIT >= (1 << CNT_W)) begin : gBadLimit
        $error("lfs_timer: LIMIT out of range");
    end

    // restarts whenever the condition drops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            done <= 1'b0;
        end else begin
            count_reg <= !hold ? '0 : (atLimit ? count_reg
                                   : count_reg + 1'b1); // [R21]
            done <= hold && atLimit;
        end
    end
endmodule : lfs_timer

// ===== logic/lfs_supervisor.sv
// led driver fault supervisor: gating, latches, lockout and shutdown timing
`timescale 1ns/10ps
`include "lfs_map.svh"
module lfs_supervisor #(
    parameter int SHUTDOWN_CYC = `LFS_SHUTDOWN_CYC,
    parameter int UV_CYC = `LFS_UV_DEGLITCH_CYC,
    parameter int START_CYC = `LFS_START_MASK_CYC,
    parameter int CHANNELS = `LFS_CHANNELS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host enable / dimming pin
    input wire logic enablePwm,
    // comparator pins
    input wire logic overvoltageSense,
    input wire logic boostSwitchNodeOver,
    input wire logic primLimitHit,
    input wire logic secLimitHit,
    input wire logic inputTripHit,
    input wire logic supplyAboveRise,
    input wire logic senseAboveRise,
    input wire logic supplyBelowFall,
    input wire logic supplyBelowAbs,
    // per-channel led pin status
    input wire logic [CHANNELS-1:0] ledOpen,
    input wire logic [CHANNELS-1:0] ledShort,
    // power stage controls
    output logic boostSwitchOn,
    output logic [CHANNELS-1:0] sinkOn,
    output logic disconnectGateOn,
    output logic fault_n,
    output logic lowPower
);
    // ------------------------------------------------------------
    // synchronised inputs
    // ------------------------------------------------------------
    localparam int SYNC_W = 10 + 2 * CHANNELS;
    logic [SYNC_W-1:0] syncBus;
    lfs_pkg::lfs_sense_t sense;
    logic enSync;
    logic [CHANNELS-1:0] openSync;
    logic [CHANNELS-1:0] shortSync;

    // refuse sizes that the logic cannot serve
    if (CHANNELS < 1 || CHANNELS > 8) begin : gBadChan
        $error("lfs_supervisor: CHANNELS out of range");
    end
    if (SHUTDOWN_CYC < 2) begin : gBadShut
        $error("lfs_supervisor: SHUTDOWN_CYC too small");
    end

    lfs_sync #(.WIDTH(SYNC_W)) uSync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn({enablePwm, overvoltageSense, boostSwitchNodeOver,
                  primLimitHit, secLimitHit, inputTripHit, supplyAboveRise,
                  senseAboveRise, supplyBelowFall, supplyBelowAbs,
                  ledOpen, ledShort}),
        .syncOut(syncBus)
    );

    // unpack the synchronised bundle
    assign enSync = syncBus[SYNC_W-1];
    assign sense = lfs_pkg::lfs_sense_t'(syncBus[SYNC_W-2 -: 9]);
    assign openSync = syncBus[2*CHANNELS-1 -: CHANNELS];
    assign shortSync = syncBus[CHANNELS-1:0];

    // ------------------------------------------------------------
    // interval timers
    // ------------------------------------------------------------
    logic uvDone;
    logic offDone;
    logic startDone;
    logic inDetect;
    logic [CHANNELS-1:0] chanOff_reg;
    lfs_pkg::lfs_state_t state_reg;
    lfs_pkg::lfs_state_t state_next;

    // falling-threshold dip must persist before it counts
    lfs_timer #(.LIMIT(UV_CYC), .CNT_W(`LFS_CNT_W)) uUvTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hold(sense.supplyBelowFall), // [R11]
        .done(uvDone)
    );

    // enable-low time counted in internal clock cycles
    lfs_timer #(.LIMIT(SHUTDOWN_CYC), .CNT_W(`LFS_CNT_W)) uOffTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hold(!enSync), // [R14] [R18]
        .done(offDone)
    );

    // startup window where some detectors are blind
    lfs_timer #(.LIMIT(START_CYC), .CNT_W(`LFS_CNT_W)) uStartTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hold(state_reg == lfs_pkg::ST_RUN),
        .done(startDone)
    );

    // ------------------------------------------------------------
    // fault decode
    // ------------------------------------------------------------
    wire supplyGood = sense.supplyAboveRise && sense.senseAboveRise; // [R10]
    wire lockout = uvDone || sense.supplyBelowAbs; // [R11] [R12]
    wire inRun = (state_reg == lfs_pkg::ST_RUN);
    // node check only once switching can begin
    wire nodeTrip = inRun && sense.nodeOverVolt; // [R4] [R5]
    // severe faults latch; input trip ignores the enable pin
    wire severe = nodeTrip || (inRun && sense.secLimit) // [R7]
                  || (state_reg != lfs_pkg::ST_OFF && sense.inputTrip); // [R8]
    wire enRise;
    logic enPrev_reg;
    assign enRise = enSync && !enPrev_reg;
    assign inDetect = (state_reg == lfs_pkg::ST_DETECT);

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    // off -> detect strings -> run; severe fault -> latched
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lfs_pkg::ST_OFF: begin
                if (enSync && supplyGood && !lockout)
                    state_next = lfs_pkg::ST_DETECT; // [R10] [R15]
            end
            lfs_pkg::ST_DETECT: begin
                if (lockout || offDone)
                    state_next = lfs_pkg::ST_OFF;
                else if (sense.inputTrip)
                    state_next = lfs_pkg::ST_LATCH; // [R8]
                else if (!(|(shortSync & ~chanOff_reg)))
                    state_next = lfs_pkg::ST_RUN; // [R5]
            end
            lfs_pkg::ST_RUN: begin
                if (lockout || offDone)
                    state_next = lfs_pkg::ST_OFF; // [R12] [R13]
                else if (severe)
                    state_next = lfs_pkg::ST_LATCH; // [R4] [R7] [R8]
            end
            lfs_pkg::ST_LATCH: begin
                // cleared only by enable shutdown or lockout
                if (lockout || offDone)
                    state_next = lfs_pkg::ST_OFF; // [R4] [R18]
            end
            default: state_next = lfs_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= lfs_pkg::ST_OFF;
            enPrev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            enPrev_reg <= enSync;
        end
    end

    // ------------------------------------------------------------
    // per-channel removal of open or shorted strings
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : gChan
            // open strings only judged at overvoltage, after startup mask
            wire openHit = inRun && startDone && sense.overVolt
                           && openSync[ch]; // [R3] [R16]
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n)
                    chanOff_reg[ch] <= 1'b0;
                else if (state_reg == lfs_pkg::ST_OFF)
                    chanOff_reg[ch] <= 1'b0; // [R13]
                else if (openHit || (inRun && shortSync[ch]))
                    chanOff_reg[ch] <= 1'b1; // [R3]
                else if (enRise)
                    chanOff_reg[ch] <= 1'b0; // [R20]
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------
    // boost needs run state, enable high and no overvoltage or limit
    // outputs drop in the cycle the state leaves run, so never on in off
    wire stayRun = inRun && (state_next == lfs_pkg::ST_RUN); // [R15]
    wire boostNext = stayRun && enSync && !severe
                     && !sense.overVolt // [R1] [R2]
                     && !sense.primLimit; // [R6]
    wire [CHANNELS-1:0] sinkNext = (stayRun && enSync && !severe)
                                   ? ~chanOff_reg
                                   : '0; // [R19]
    // disconnect stays on through auto-restart faults
    wire gateNext = (state_next == lfs_pkg::ST_DETECT)
                    || (state_next == lfs_pkg::ST_RUN); // [R9]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boostSwitchOn <= 1'b0;
            sinkOn <= '0;
            disconnectGateOn <= 1'b0;
            fault_n <= 1'b1;
            lowPower <= 1'b1;
        end else begin
            boostSwitchOn <= boostNext && !lockout;
            sinkOn <= lockout ? '0 : sinkNext; // [R15]
            disconnectGateOn <= gateNext;
            fault_n <= !(state_next == lfs_pkg::ST_LATCH); // [R9]
            lowPower <= (state_next == lfs_pkg::ST_OFF);
        end
    end
endmodule : lfs_supervisor

// ===== verif/lfs_supervisor_props.sv
// concurrent checks on the led fault supervisor ports
`timescale 1ns/10ps
module lfs_supervisor_props #(
    parameter int SHUTDOWN_CYC = 32750,
    parameter int CHANNELS = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // causes
    input wire logic enablePwm,
    input wire logic overvoltageSense,
    input wire logic boostSwitchNodeOver,
    input wire logic secLimitHit,
    input wire logic inputTripHit,
    input wire logic supplyBelowFall,
    input wire logic supplyBelowAbs,
    // effects
    input wire logic boostSwitchOn,
    input wire logic [CHANNELS-1:0] sinkOn,
    input wire logic disconnectGateOn,
    input wire logic fault_n,
    input wire logic lowPower
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // length of the current enable-low run
    int enLowCnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            enLowCnt <= 0;
        else
            enLowCnt <= enablePwm ? 0 : enLowCnt + 1;
    end
    // -----------------------------------------
    // properties: slack covers the sync stages
    // -----------------------------------------
    property p_ovStop;
        overvoltageSense [*4] |-> !boostSwitchOn;
    endproperty
    a_ovStop: assert property (p_ovStop) else $error("boost on in ov");
    property p_enOff;
        !enablePwm [*4] |-> !boostSwitchOn && sinkOn == '0;
    endproperty
    a_enOff: assert property (p_enOff) else $error("run with en low");
    property p_faultOff;
        !fault_n |-> !boostSwitchOn && !disconnectGateOn && sinkOn == '0;
    endproperty
    a_faultOff: assert property (p_faultOff) else $error("stage on");
    property p_trip;
        inputTripHit && boostSwitchOn |-> ##[1:4] !fault_n;
    endproperty
    a_trip: assert property (p_trip) else $error("trip missed");
    property p_sec;
        secLimitHit && boostSwitchOn |-> ##[1:4] !boostSwitchOn
            && !disconnectGateOn;
    endproperty
    a_sec: assert property (p_sec) else $error("sec limit missed");
    property p_node;
        boostSwitchNodeOver && boostSwitchOn |-> ##[1:4] !fault_n;
    endproperty
    a_node: assert property (p_node) else $error("node ov missed");
    property p_latchHold;
        (enablePwm && !supplyBelowFall && !supplyBelowAbs) [*4] ##0 !fault_n
            |=> !fault_n;
    endproperty
    a_latchHold: assert property (p_latchHold) else $error("no hold");
    property p_shut;
        enLowCnt == SHUTDOWN_CYC + 6 |-> lowPower && fault_n;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_offQuiet;
        lowPower |-> fault_n && !boostSwitchOn && sinkOn == '0;
    endproperty
    a_offQuiet: assert property (p_offQuiet) else $error("off busy");
    property p_uvAbs;
        supplyBelowAbs [*4] |-> lowPower;
    endproperty
    a_uvAbs: assert property (p_uvAbs) else $error("no lockout");
    c_fault: cover property (!fault_n);
    c_wake: cover property (lowPower ##1 !lowPower);
    c_ov: cover property (overvoltageSense && boostSwitchOn);
endmodule : lfs_supervisor_props
bind lfs_supervisor lfs_supervisor_props #(
    .SHUTDOWN_CYC(SHUTDOWN_CYC),
    .CHANNELS(CHANNELS)
) i_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .enablePwm(enablePwm),
    .overvoltageSense(overvoltageSense),
    .boostSwitchNodeOver(boostSwitchNodeOver),
    .secLimitHit(secLimitHit), .inputTripHit(inputTripHit),
    .supplyBelowFall(supplyBelowFall), .supplyBelowAbs(supplyBelowAbs),
    .boostSwitchOn(boostSwitchOn), .sinkOn(sinkOn),
    .disconnectGateOn(disconnectGateOn), .fault_n(fault_n),
    .lowPower(lowPower)
);

// ===== verif/lfs_host.sv
// host model driving the enable / dimming pin
`timescale 1ns/10ps
module lfs_host (
    // clock
    input wire logic sys_clk,
    // enable / dimming pin
    output logic enablePwm
);
    // starts low so the block stays shut down until asked
    initial enablePwm = 1'b0;
    // level changes land just after an edge
    task automatic set_level(input logic lvl);
        @(posedge sys_clk);
        enablePwm <= lvl;
    endtask : set_level
    // long low clears a latch; no faster path modelled
    task automatic hold_low(input int n);
        set_level(1'b0);
        repeat (n) @(posedge sys_clk);
    endtask : hold_low
endmodule : lfs_host

// ===== verif/lfs_supervisor_tb_top.sv
// self-checking bench for the led fault supervisor
`timescale 1ns/10ps
module lfs_supervisor_tb_top;
    localparam int SD = 20;
    logic sys_clk;
    logic rst_n;
    logic enablePwm;
    lfs_pkg::lfs_sense_t sense;
    logic [1:0] ledOpen;
    logic [1:0] ledShort;
    logic boostSwitchOn;
    logic [1:0] sinkOn;
    logic disconnectGateOn;
    logic fault_n;
    logic lowPower;
    int fails;
    int checked;
    int mRun;
    int mOff;
    int mFault;
    int len;
    lfs_supervisor #(.SHUTDOWN_CYC(SD), .UV_CYC(10), .START_CYC(8)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .enablePwm(enablePwm),
        .overvoltageSense(sense.overVolt),
        .boostSwitchNodeOver(sense.nodeOverVolt),
        .primLimitHit(sense.primLimit), .secLimitHit(sense.secLimit),
        .inputTripHit(sense.inputTrip),
        .supplyAboveRise(sense.supplyAboveRise),
        .senseAboveRise(sense.senseAboveRise),
        .supplyBelowFall(sense.supplyBelowFall),
        .supplyBelowAbs(sense.supplyBelowAbs),
        .ledOpen(ledOpen), .ledShort(ledShort),
        .boostSwitchOn(boostSwitchOn), .sinkOn(sinkOn),
        .disconnectGateOn(disconnectGateOn), .fault_n(fault_n),
        .lowPower(lowPower)
    );
    lfs_host i_host (.sys_clk(sys_clk), .enablePwm(enablePwm));
    // 250 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // bit numbers follow the packed sense struct, overVolt = 8
    task automatic pin(input int b, input logic v);
        @(posedge sys_clk);
        sense[b] <= v;
    endtask : pin
    // sample at the falling edge so the outputs have settled
    task automatic model_chk();
        @(negedge sys_clk);
        chk("boost", 8'(boostSwitchOn), 8'(mRun));
        chk("sinks", 8'(sinkOn), mRun != 0 ? 8'h03 : 8'h00);
        chk("gate", 8'(disconnectGateOn), 8'(mOff == 0 && mFault == 0));
        chk("fault_n", 8'(fault_n), 8'(mFault == 0));
        chk("lowPower", 8'(lowPower), 8'(mOff));
    endtask : model_chk
    // bounded wait for switching to start
    task automatic start();
        i_host.set_level(1'b1);
        for (int i = 0; i < 20 && boostSwitchOn !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        mOff = 0;
        mRun = 1;
        model_chk();
    endtask : start
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // watchdog well past the expected run
    initial begin
        cyc(20000);
        fails++;
        results();
    end
    // ----------------
    // main sequence
    // ----------------
    initial begin
        void'($urandom(32'hee9c));
        rst_n = 1'b0;
        sense = 9'h00c;
        ledOpen = 2'h0;
        ledShort = 2'h0;
        {fails, checked, mRun, mFault} = '0;
        mOff = 1;
        cyc(20);
        rst_n <= 1'b1;
        model_chk();
        pin(2, 1'b0);
        i_host.set_level(1'b1);
        cyc(10);
        model_chk();
        pin(2, 1'b1);
        start();
        // one-cycle overvoltage inside the startup mask keeps both strings
        pin(8, 1'b1);
        ledOpen <= 2'h1;
        pin(8, 1'b0);
        ledOpen <= 2'h0;
        cyc(6);
        model_chk();
        // open string at overvoltage is dropped until the next enable rise
        pin(8, 1'b1);
        ledOpen <= 2'h1;
        cyc(5);
        @(negedge sys_clk);
        chk("ov boost", 8'(boostSwitchOn), 8'h00);
        chk("ov sinks", 8'(sinkOn), 8'h02);
        pin(8, 1'b0);
        ledOpen <= 2'h0;
        cyc(6);
        @(negedge sys_clk);
        chk("ov end boost", 8'(boostSwitchOn), 8'h01);
        chk("ov end sinks", 8'(sinkOn), 8'h02);
        i_host.set_level(1'b0);
        i_host.set_level(1'b1);
        cyc(6);
        model_chk();
        // primary limit blanks exactly one switching cycle
        pin(6, 1'b1);
        pin(6, 1'b0);
        cyc(2);
        @(negedge sys_clk);
        chk("limit boost", 8'(boostSwitchOn), 8'h00);
        cyc(6);
        model_chk();
        for (int k = 0; k < 3; k++) begin
            len = k == 0 ? 7 : (k == 1 ? 5 : 4);
            pin(len, 1'b1);
            pin(len, 1'b0);
            cyc(6);
            mFault = 1;
            mRun = 0;
            model_chk();
            cyc(10);
            model_chk();
            i_host.hold_low(SD + 8);
            mFault = 0;
            mOff = 1;
            model_chk();
            start();
        end
        pin(1, 1'b1);
        cyc(5);
        pin(1, 1'b0);
        cyc(4);
        model_chk();
        pin(1, 1'b1);
        cyc(16);
        mRun = 0;
        mOff = 1;
        model_chk();
        pin(1, 1'b0);
        start();
        pin(0, 1'b1);
        cyc(4);
        mRun = 0;
        mOff = 1;
        model_chk();
        pin(0, 1'b0);
        start();
        repeat (12) begin
            len = 6 + $urandom % 10;
            mRun = $urandom % 2;
            i_host.set_level(1'(mRun));
            cyc(len);
            @(negedge sys_clk);
            chk("dim boost", 8'(boostSwitchOn), 8'(mRun));
            chk("dim sinks", 8'(sinkOn), mRun != 0 ? 8'h03 : 8'h00);
        end
        results();
    end
endmodule : lfs_supervisor_tb_top
